/* logic/gcl_pkg.sv */
// Purpose: shared constants and types of the port clear and configuration lock block
// Assumes: 8 pins, registers at byte offsets on a simple word access port
// Notes: the lock register offset is local to this block
package gcl_pkg;

    // ****************************************************
    // sizes
    // ****************************************************
    localparam int GCL_PINS = 8;
    localparam int GCL_DW = 32;
    localparam int GCL_AW = 8;
    localparam int GCL_NIB = 4;

    // ****************************************************
    // register offsets
    // ****************************************************
    localparam logic [7:0] GCL_OFS_CFG_LOW = 8'h00;
    localparam logic [7:0] GCL_OFS_CFG_HIGH = 8'h04;
    localparam logic [7:0] GCL_OFS_OUT_LATCH = 8'h0C;
    localparam logic [7:0] GCL_OFS_OUT_CLEAR = 8'h14;
    localparam logic [7:0] GCL_OFS_CFG_LOCK = 8'h18;

    // ****************************************************
    // field positions and reset values
    // ****************************************************
    localparam int GCL_LOCK_KEY_POS = 8;
    localparam int GCL_MODE_W = 2;
    localparam logic [1:0] GCL_MODE_INPUT = 2'h0;
    localparam logic [31:0] GCL_CFG_RST = 32'h44444444;
    localparam logic [7:0] GCL_BYTE_ZERO = 8'h00;
    localparam logic [31:0] GCL_WORD_ZERO = 32'h00000000;

    // ****************************************************
    // types
    // ****************************************************
    typedef struct packed {
        logic req;
        logic we;
        logic [GCL_AW-1:0] addr;
        logic [GCL_DW-1:0] wdata;
    } gcl_bus_req_t;

    typedef struct packed {
        logic rvalid;
        logic [GCL_DW-1:0] rdata;
    } gcl_bus_rsp_t;

    typedef enum logic [1:0] {
        GCL_SEQ_IDLE,
        GCL_SEQ_GOT_ONE,
        GCL_SEQ_GOT_ZERO
    } gcl_seq_t;

endpackage

/* logic/gcl_lock_seq.sv */
// Purpose: tracks the lock key write sequence and holds the lock flag
// Assumes: one lock register access per strobe
// Notes: lock stays set until reset
`timescale 1ns/1ps
module gcl_lock_seq
    import gcl_pkg::*;
#(
    parameter int PINS = GCL_PINS
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic key_in,
    input wire logic [PINS-1:0] sel_in,
    output logic locked_out
);

    typedef struct packed {
        gcl_seq_t st;
        logic [PINS-1:0] first_sel;
        logic locked;
    } gcl_seq_state_t;

    gcl_seq_state_t s_q;
    gcl_seq_state_t s_d;

    // ****************************************************
    // sequence tracking
    // ****************************************************
    always_comb begin
        s_d = s_q;
        if (s_q.locked) begin
            s_d.st = GCL_SEQ_IDLE;
        end else if (wr_in) begin
            case (s_q.st)
                GCL_SEQ_IDLE: begin
                    if (key_in) begin
                        s_d.st = GCL_SEQ_GOT_ONE;
                        s_d.first_sel = sel_in;
                    end
                end
                GCL_SEQ_GOT_ONE: begin
                    if (!key_in && sel_in == s_q.first_sel) begin
                        s_d.st = GCL_SEQ_GOT_ZERO;
                    end else begin
                        s_d.st = GCL_SEQ_IDLE;
                    end
                end
                GCL_SEQ_GOT_ZERO: begin
                    s_d.st = GCL_SEQ_IDLE;
                    if (key_in && sel_in == s_q.first_sel) begin
                        s_d.locked = 1'b1;
                    end
                end
                default: begin
                    s_d.st = GCL_SEQ_IDLE;
                end
            endcase
        end else if (rd_in) begin
            s_d.st = GCL_SEQ_IDLE;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q <= '{st: GCL_SEQ_IDLE, first_sel: '0, locked: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign locked_out = s_q.locked;

endmodule // gcl_lock_seq

/* logic/gcl_port.sv */
// Purpose: output latch clear register, configuration registers and configuration lock
// Assumes: software keeps to 32-bit accesses and stable select bits during the key sequence
// Notes: read data arrive one cycle after the read strobe
`timescale 1ns/1ps
module gcl_port
    import gcl_pkg::*;
#(
    parameter int PINS = GCL_PINS,
    parameter logic [31:0] CFG_RESET = GCL_CFG_RST
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire gcl_bus_req_t bus_req_in,
    output gcl_bus_rsp_t bus_rsp_out,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe_out,
    output logic [GCL_DW-1:0] pin_config_low_out,
    output logic [GCL_DW-1:0] pin_config_high_out,
    output logic lock_key_out
);

    typedef struct packed {
        logic [GCL_DW-1:0] cfg_low;
        logic [GCL_DW-1:0] cfg_high;
        logic [PINS-1:0] output_latch;
        logic [PINS-1:0] pin_lock_bit;
        gcl_bus_rsp_t rsp;
    } gcl_port_state_t;

    gcl_port_state_t s_q;
    gcl_port_state_t s_d;
    logic locked;
    logic lock_wr;
    logic lock_rd;

    // ****************************************************
    // helpers
    // ****************************************************
    // keep the nibbles of locked pins, take the rest from the write
    function automatic logic [GCL_DW-1:0] gcl_merge_cfg(input logic [GCL_DW-1:0] old_v,
                                                          input logic [GCL_DW-1:0] new_v,
                                                          input logic [PINS-1:0] guard);
        logic [GCL_DW-1:0] r;
        r = new_v;
        for (int i = 0; i < PINS; i++) begin
            if (guard[i]) begin
                r[i*GCL_NIB +: GCL_NIB] = old_v[i*GCL_NIB +: GCL_NIB];
            end
        end
        return r;
    endfunction

    // ****************************************************
    // lock sequence
    // ****************************************************
    assign lock_wr = bus_req_in.req && bus_req_in.we && bus_req_in.addr == GCL_OFS_CFG_LOCK;
    assign lock_rd = bus_req_in.req && !bus_req_in.we && bus_req_in.addr == GCL_OFS_CFG_LOCK;

    gcl_lock_seq #(
        .PINS(PINS)
    ) u_seq (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .wr_in(lock_wr),
        .rd_in(lock_rd),
        .key_in(bus_req_in.wdata[GCL_LOCK_KEY_POS]),
        .sel_in(bus_req_in.wdata[PINS-1:0]),
        .locked_out(locked)
    );

    // ****************************************************
    // register access
    // ****************************************************
    always_comb begin
        logic [PINS-1:0] guard;
        guard = locked ? s_q.pin_lock_bit : '0;
        s_d = s_q;
        s_d.rsp.rvalid = 1'b0;
        if (bus_req_in.req && bus_req_in.we) begin
            if (bus_req_in.addr == GCL_OFS_CFG_LOW) begin
                s_d.cfg_low = gcl_merge_cfg(s_q.cfg_low, bus_req_in.wdata, guard);
            end else if (bus_req_in.addr == GCL_OFS_CFG_HIGH) begin
                s_d.cfg_high = gcl_merge_cfg(s_q.cfg_high, bus_req_in.wdata, guard);
            end else if (bus_req_in.addr == GCL_OFS_OUT_LATCH) begin
                s_d.output_latch = bus_req_in.wdata[PINS-1:0];
            end else if (bus_req_in.addr == GCL_OFS_OUT_CLEAR) begin
                s_d.output_latch = s_q.output_latch & ~bus_req_in.wdata[PINS-1:0];
            end else if (bus_req_in.addr == GCL_OFS_CFG_LOCK) begin
                if (!locked) begin
                    s_d.pin_lock_bit = bus_req_in.wdata[PINS-1:0];
                end
            end
        end else if (bus_req_in.req) begin
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata = GCL_WORD_ZERO;
            if (bus_req_in.addr == GCL_OFS_CFG_LOW) begin
                s_d.rsp.rdata = s_q.cfg_low;
            end else if (bus_req_in.addr == GCL_OFS_CFG_HIGH) begin
                s_d.rsp.rdata = s_q.cfg_high;
            end else if (bus_req_in.addr == GCL_OFS_OUT_LATCH) begin
                s_d.rsp.rdata[PINS-1:0] = s_q.output_latch;
            end else if (bus_req_in.addr == GCL_OFS_CFG_LOCK) begin
                s_d.rsp.rdata[GCL_LOCK_KEY_POS] = locked;
                s_d.rsp.rdata[PINS-1:0] = s_q.pin_lock_bit;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q.cfg_low <= CFG_RESET;
            s_q.cfg_high <= CFG_RESET;
            s_q.output_latch <= GCL_BYTE_ZERO;
            s_q.pin_lock_bit <= GCL_BYTE_ZERO;
            s_q.rsp <= '{rvalid: 1'b0, rdata: GCL_WORD_ZERO};
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************
    // pin drive
    // ****************************************************
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            pin_oe_out[i] = s_q.cfg_low[i*GCL_NIB +: GCL_MODE_W] != GCL_MODE_INPUT;
        end
    end

    assign pin_out = s_q.output_latch;
    assign bus_rsp_out = s_q.rsp;
    assign pin_config_low_out = s_q.cfg_low;
    assign pin_config_high_out = s_q.cfg_high;
    assign lock_key_out = locked;

endmodule // gcl_port

/* verif/gcl_port_props.sv */
// Purpose: checker for gcl_port
// Assumes: 8 pins
// Notes: bound at file foot
`timescale 1ns/1ps
module gcl_port_props
    import gcl_pkg::*;
#(
    parameter int PINS = GCL_PINS
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire gcl_bus_req_t bus_req_in,
    input wire gcl_bus_rsp_t bus_rsp_out,
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe_out,
    input wire logic [GCL_DW-1:0] pin_config_low_out,
    input wire logic [GCL_DW-1:0] pin_config_high_out,
    input wire logic lock_key_out
);
    // ****
    // helpers
    // ****
    logic wr, rd;
    logic [7:0] a;
    logic [PINS-1:0] sel_q, oe;
    logic [GCL_DW-1:0] m;
    assign wr = bus_req_in.req & bus_req_in.we;
    assign rd = bus_req_in.req & ~bus_req_in.we;
    assign a = bus_req_in.addr;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            sel_q <= '0;
        else if (wr && a == GCL_OFS_CFG_LOCK && !lock_key_out)
            sel_q <= bus_req_in.wdata[PINS-1:0];
    end
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            m[4*i+:4] = {4{sel_q[i]}};
            oe[i] = |pin_config_low_out[4*i+:2];
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    a_clear_bits: assert property (wr && a == GCL_OFS_OUT_CLEAR |=>
        pin_out == ($past(pin_out) & ~$past(bus_req_in.wdata[PINS-1:0]))) else $error("clear wrong");
    a_read_answer: assert property (1 |=> bus_rsp_out.rvalid == $past(rd)) else $error("rvalid wrong");
    a_lock_read: assert property (rd && a == GCL_OFS_CFG_LOCK |=>
        bus_rsp_out.rdata == {23'h0, $past(lock_key_out), $past(sel_q)}) else $error("lock read wrong");
    a_clear_reads_zero: assert property (rd && a == GCL_OFS_OUT_CLEAR |=>
        bus_rsp_out.rdata == GCL_WORD_ZERO) else $error("clear read wrong");
    a_lock_sticky: assert property (lock_key_out |=> lock_key_out) else $error("lock lost");
    a_lock_cause: assert property ($rose(lock_key_out) |->
        $past(wr && a == GCL_OFS_CFG_LOCK && bus_req_in.wdata[GCL_LOCK_KEY_POS])) else $error("lock cause");
    a_low_held: assert property (lock_key_out && wr && a == GCL_OFS_CFG_LOW |=>
        ((pin_config_low_out ^ $past(pin_config_low_out)) & m) == '0) else $error("low changed");
    a_high_held: assert property (lock_key_out && wr && a == GCL_OFS_CFG_HIGH |=>
        ((pin_config_high_out ^ $past(pin_config_high_out)) & m) == '0) else $error("high changed");
    a_oe_mode: assert property (pin_oe_out == oe) else $error("oe wrong");
    c_lock: cover property ($rose(lock_key_out));
    c_clear: cover property (wr && a == GCL_OFS_OUT_CLEAR);
    c_locked_wr: cover property (lock_key_out && wr && a == GCL_OFS_CFG_LOW);
endmodule // gcl_port_props
bind gcl_port gcl_port_props #(.PINS(PINS)) u_gcl_port_props (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .bus_req_in(bus_req_in), .bus_rsp_out(bus_rsp_out), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
    .pin_config_low_out(pin_config_low_out), .pin_config_high_out(pin_config_high_out),
    .lock_key_out(lock_key_out));

/* verif/tb_gpio_clear_and_config_lock.sv */
// Purpose: bench for gcl_port
// Assumes: lock register at 0x18
// Notes: ends in wrap_up
`timescale 1ns/1ps
module tb_gpio_clear_and_config_lock;
    import gcl_pkg::*;
    logic clk_in = 1'h0;
    logic reset_n_in = 1'h0;
    gcl_bus_req_t bus_req_in = '0;
    gcl_bus_rsp_t bus_rsp_out;
    logic [7:0] pin_out, pin_oe_out;
    logic [31:0] cfg_lo, cfg_hi;
    logic lock_key_out;
    int n_fail = 0;
    int n_compared = 0;
    always #12.5 clk_in = ~clk_in;
    gcl_port u_gcl_port (.clk_in(clk_in), .reset_n_in(reset_n_in), .bus_req_in(bus_req_in),
        .bus_rsp_out(bus_rsp_out), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
        .pin_config_low_out(cfg_lo), .pin_config_high_out(cfg_hi), .lock_key_out(lock_key_out));
    // ****
    // tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        bus_req_in <= '{1'h1, 1'h1, a, d};
        @(posedge clk_in);
        bus_req_in.req <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        bus_req_in <= '{1'h1, 1'h0, a, 32'h0};
        @(posedge clk_in);
        bus_req_in.req <= 1'h0;
        #1;
        chk({31'h0, bus_rsp_out.rvalid}, 32'h1);
        chk(bus_rsp_out.rdata, exp);
    endtask
    task automatic key(input logic k, input logic [7:0] s);
        wr(GCL_OFS_CFG_LOCK, {23'h0, k, s});
    endtask
    task automatic st(input logic l, input logic [7:0] o, input logic [7:0] p);
        @(posedge clk_in);
        #1;
        chk({15'h0, lock_key_out, pin_oe_out, pin_out}, {15'h0, l, o, p});
    endtask
    task automatic wrap_up;
        $display("compared=%0d failed=%0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ****
    // tests
    // ****
    initial begin
        repeat (2000) @(posedge clk_in);
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'h1;
        st(1'h0, 8'h00, 8'h00);
        rd(GCL_OFS_CFG_LOCK, 32'h0);
        wr(GCL_OFS_CFG_LOW, 32'h44444411);
        wr(GCL_OFS_OUT_LATCH, 32'hFF);
        st(1'h0, 8'h03, 8'hFF);
        wr(GCL_OFS_OUT_CLEAR, 32'h05);
        st(1'h0, 8'h03, 8'hFA);
        wr(GCL_OFS_OUT_CLEAR, 32'h00);
        st(1'h0, 8'h03, 8'hFA);
        rd(GCL_OFS_OUT_CLEAR, 32'h0);
        rd(GCL_OFS_OUT_LATCH, 32'hFA);
        rd(8'h40, 32'h0);
        key(1'h1, 8'h01);
        key(1'h0, 8'h01);
        key(1'h0, 8'h01);
        key(1'h1, 8'h01);
        rd(GCL_OFS_CFG_LOCK, 32'h001);
        key(1'h1, 8'h03);
        key(1'h0, 8'h01);
        key(1'h1, 8'h01);
        rd(GCL_OFS_CFG_LOCK, 32'h001);
        key(1'h1, 8'h01);
        rd(GCL_OFS_CFG_LOCK, 32'h001);
        key(1'h0, 8'h01);
        key(1'h1, 8'h01);
        rd(GCL_OFS_CFG_LOCK, 32'h001);
        key(1'h0, 8'h01);
        key(1'h1, 8'h01);
        key(1'h0, 8'h01);
        key(1'h1, 8'h01);
        rd(GCL_OFS_CFG_LOCK, 32'h101);
        wr(GCL_OFS_CFG_LOCK, 32'hFF);
        rd(GCL_OFS_CFG_LOCK, 32'h101);
        wr(GCL_OFS_CFG_LOW, 32'h22222222);
        rd(GCL_OFS_CFG_LOW, 32'h22222221);
        chk(cfg_lo, 32'h22222221);
        wr(GCL_OFS_CFG_HIGH, 32'h33333333);
        rd(GCL_OFS_CFG_HIGH, 32'h33333334);
        chk(cfg_hi, 32'h33333334);
        st(1'h1, 8'hFF, 8'hFA);
        @(posedge clk_in);
        reset_n_in <= 1'h0;
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'h1;
        st(1'h0, 8'h00, 8'h00);
        wr(GCL_OFS_CFG_LOW, 32'h22222222);
        rd(GCL_OFS_CFG_LOW, 32'h22222222);
        chk(cfg_lo, 32'h22222222);
        chk(cfg_hi, GCL_CFG_RST);
        wrap_up();
    end
endmodule // tb_gpio_clear_and_config_lock
